// file: hdl/flcs_fuse_lock_config_store.sv
// fuse bytes, boot lock decode, signature row and page geometry
//
// Contract
// RULE_01 - mode 1: boot section fully accessible
// RULE_02 - mode 2: stores into boot section blocked
// RULE_03 - mode 3: block boot stores, app loads
// RULE_04 - mode 4: block app loads from boot
// RULE_05 - modes 3,4: mask interrupts inside boot
// RULE_06 - programmed bits read zero, unprogrammed one
// RULE_07 - high fuse bits 7:5 debug, scan, serial
// RULE_08 - high bit 4 osc, bit 3 preserve
// RULE_09 - high bits 2:1 boot size, 0 vector
// RULE_10 - serial enable fuse frozen in serial mode
// RULE_11 - low bits 7:4 brownout and start-up
// RULE_12 - low bits 3:0 clock source, default 0001
// RULE_13 - chip erase leaves fuses unchanged
// RULE_14 - general lock programmed refuses fuse writes
// RULE_15 - programmer writes fuses before lock bits
// RULE_16 - fuses latched at programming entry, apply after
// RULE_17 - eeprom preserve fuse applies immediately
// RULE_18 - fuses latched at power-up in normal mode
// RULE_19 - three identity bytes, always readable
// RULE_20 - four calibration bytes in high byte
// RULE_21 - reset loads 1 MHz calibration byte
// RULE_22 - flash 128 pages of 64 words
// RULE_23 - eeprom 128 pages of 4 bytes
// RULE_24 - combinational boot store/load permission decode; code registers store_permit_q and load_permit_q
`timescale 1ns/1ps
module flcs_fuse_lock_config_store #(
  parameter logic [7:0] ID_BYTE0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] ID_BYTE1 = 8'h3c, // arbitrary identity value
  parameter logic [7:0] ID_BYTE2 = 8'h71, // arbitrary identity value
  parameter logic [7:0] CAL_1MHZ = 8'h80,
  parameter logic [7:0] CAL_2MHZ = 8'h81,
  parameter logic [7:0] CAL_4MHZ = 8'h82,
  parameter logic [7:0] CAL_8MHZ = 8'h83
) (
  input wire logic clk,
  input wire logic rst,
  // programmer side (pins, resynchronised here)
  input wire logic prog_mode_pin,
  input wire logic serial_mode_pin,
  // programmer command strobes (same clock)
  input wire logic fuse_wr_en,
  input wire logic fuse_wr_high,
  input wire logic [7:0] fuse_wr_data,
  input wire logic fuse_rd_en,
  input wire logic fuse_rd_high,
  output logic [7:0] fuse_rd_data_q,
  input wire logic sig_rd_en,
  input wire logic sig_rd_high,
  input wire logic [1:0] sig_rd_addr,
  output logic [7:0] sig_rd_data_q,
  // lock byte from the lock store
  input wire logic [7:0] lock_bits,
  // cpu side
  input wire logic [12:0] exec_pc,
  input wire logic [12:0] target_addr,
  input wire logic vectors_in_boot,
  input wire logic osc_trim_wr,
  input wire logic [7:0] osc_trim_wdata,
  output logic [7:0] osc_trim_register_q,
  output logic store_permit_q,
  output logic load_permit_q,
  output logic irq_block_q,
  // active fuse values seen by the rest of the chip
  output logic [7:0] fuse_high_active_q,
  output logic [7:0] fuse_low_active_q,
  output logic eeprom_preserve_q,
  // page geometry
  input wire logic [8:0] eeprom_addr,
  output logic [6:0] page_number_q,
  output logic [5:0] page_word_index_q,
  output logic [6:0] ee_page_number_q,
  output logic [1:0] ee_byte_index_q
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // boot section start word from the boot size bits
  function automatic logic [12:0] boot_start(input logic [1:0] sz);
    logic [12:0] r;
    r = flcs_pkg::BOOT_START_SZ00;
    case (sz)
      2'b11: r = flcs_pkg::BOOT_START_SZ11;
      2'b10: r = flcs_pkg::BOOT_START_SZ10;
      2'b01: r = flcs_pkg::BOOT_START_SZ01;
      default: r = flcs_pkg::BOOT_START_SZ00;
    endcase
    return r;
  endfunction

  // true when a word address lies in the boot section
  function automatic logic in_boot(input logic [12:0] a,
                                   input logic [1:0] sz);
    return a >= boot_start(sz);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] prog_sync_q, prog_sync_d; // three-stage prog mode
  logic [2:0] ser_sync_q, ser_sync_d; // three-stage serial mode
  logic prog_mode_q, prog_mode_d; // filtered prog mode
  logic serial_mode_q, serial_mode_d; // filtered serial mode

  // shift pins in, accept once stages two and three agree
  always_comb begin
    prog_sync_d = {prog_sync_q[1:0], prog_mode_pin};
    ser_sync_d = {ser_sync_q[1:0], serial_mode_pin};
    prog_mode_d = prog_mode_q;
    serial_mode_d = serial_mode_q;
    if (prog_sync_q[1] == prog_sync_q[2]) begin
      prog_mode_d = prog_sync_q[2];
    end
    if (ser_sync_q[1] == ser_sync_q[2]) begin
      serial_mode_d = ser_sync_q[2];
    end
  end

  // register synchroniser stages
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_sync_q <= 3'h0;
      ser_sync_q <= 3'h0;
      prog_mode_q <= 1'b0;
      serial_mode_q <= 1'b0;
    end else begin
      prog_sync_q <= prog_sync_d;
      ser_sync_q <= ser_sync_d;
      prog_mode_q <= prog_mode_d;
      serial_mode_q <= serial_mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fuse storage and latching

  logic [7:0] fuse_high_nv_q, fuse_high_nv_d; // stored high byte
  logic [7:0] fuse_low_nv_q, fuse_low_nv_d; // stored low byte
  logic [7:0] fuse_high_act_d, fuse_low_act_d; // active copies
  logic pwr_up_q, pwr_up_d; // first cycle after reset
  logic prog_prev_q, prog_prev_d; // prog mode last cycle
  logic ee_keep_d; // effective preserve flag
  logic fuse_wr_ok; // write allowed by lock state
  logic [7:0] fuse_rd_d; // read data next value

  // write, latch and read the fuse bytes
  always_comb begin
    fuse_high_nv_d = fuse_high_nv_q;
    fuse_low_nv_d = fuse_low_nv_q;
    fuse_high_act_d = fuse_high_active_q;
    fuse_low_act_d = fuse_low_active_q;
    fuse_rd_d = fuse_rd_data_q;
    pwr_up_d = 1'b0;
    prog_prev_d = prog_mode_q;
    // RULE_14 general lock check
    fuse_wr_ok = fuse_wr_en & prog_mode_q &
                 lock_bits[flcs_pkg::LOCK_GENERAL_FIRST_BIT];
    // RULE_13 no erase path here
    if (fuse_wr_ok) begin
      if (fuse_wr_high) begin
        fuse_high_nv_d = fuse_wr_data;
        // RULE_10 serial enable frozen
        if (serial_mode_q) begin
          fuse_high_nv_d[flcs_pkg::HI_SERIAL_PROG_BIT] =
            fuse_high_nv_q[flcs_pkg::HI_SERIAL_PROG_BIT];
        end
      end else begin
        fuse_low_nv_d = fuse_wr_data;
      end
    end
    // RULE_18 latch at power-up
    if (pwr_up_q && !prog_mode_q) begin
      fuse_high_act_d = fuse_high_nv_q;
      fuse_low_act_d = fuse_low_nv_q;
    // RULE_16 latch on entry and exit
    end else if (prog_mode_q != prog_prev_q) begin
      fuse_high_act_d = fuse_high_nv_q;
      fuse_low_act_d = fuse_low_nv_q;
    end
    // RULE_17 preserve takes effect at once
    ee_keep_d = ~fuse_high_nv_q[flcs_pkg::HI_EE_PRESERVE_BIT] |
                ~fuse_high_active_q[flcs_pkg::HI_EE_PRESERVE_BIT];
    // RULE_06 raw bits, zero means programmed
    if (fuse_rd_en) begin
      fuse_rd_d = fuse_rd_high ? fuse_high_nv_q : fuse_low_nv_q;
    end
  end

  // register fuse state; reset stands for power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      // RULE_07 high fuse defaults
      // RULE_08 osc option and preserve defaults
      // RULE_09 largest boot, vector default
      fuse_high_nv_q <= flcs_pkg::FUSE_HIGH_RESET;
      // RULE_11 brownout and start-up defaults
      // RULE_12 internal rc 1 MHz default
      fuse_low_nv_q <= flcs_pkg::FUSE_LOW_RESET;
      fuse_high_active_q <= flcs_pkg::FUSE_HIGH_RESET;
      fuse_low_active_q <= flcs_pkg::FUSE_LOW_RESET;
      fuse_rd_data_q <= flcs_pkg::UNMAPPED_READ;
      eeprom_preserve_q <= 1'b0;
      pwr_up_q <= 1'b1;
      prog_prev_q <= 1'b0;
    end else begin
      fuse_high_nv_q <= fuse_high_nv_d;
      fuse_low_nv_q <= fuse_low_nv_d;
      fuse_high_active_q <= fuse_high_act_d;
      fuse_low_active_q <= fuse_low_act_d;
      fuse_rd_data_q <= fuse_rd_d;
      eeprom_preserve_q <= ee_keep_d;
      pwr_up_q <= pwr_up_d;
      prog_prev_q <= prog_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boot lock decode

  flcs_pkg::flcs_boot_lock_t lock_mode; // current boot lock mode
  logic [1:0] boot_sz; // active boot size bits
  logic exec_boot, target_boot; // section flags
  logic store_d, load_d, irq_d; // permission next values

  // decode permissions from lock mode and sections
  always_comb begin
    lock_mode = flcs_pkg::flcs_boot_lock_t'(
      {lock_bits[flcs_pkg::LOCK_BOOT_UPPER_BIT],
       lock_bits[flcs_pkg::LOCK_BOOT_LOWER_BIT]});
    boot_sz = {fuse_high_active_q[flcs_pkg::HI_BOOT_SIZE_HI_BIT],
               fuse_high_active_q[flcs_pkg::HI_BOOT_SIZE_LO_BIT]};
    exec_boot = in_boot(exec_pc, boot_sz);
    target_boot = in_boot(target_addr, boot_sz);
    store_d = 1'b1;
    load_d = 1'b1;
    irq_d = 1'b0;
    // RULE_24 per-mode permission decode
    case (lock_mode)
      // RULE_01 unrestricted
      flcs_pkg::FLCS_BLOCK_M1: begin
        store_d = 1'b1;
        load_d = 1'b1;
      end
      // RULE_02 stores into boot blocked
      flcs_pkg::FLCS_BLOCK_M2: begin
        store_d = ~target_boot;
      end
      // RULE_03 stores and app loads blocked
      flcs_pkg::FLCS_BLOCK_M3: begin
        store_d = ~target_boot;
        load_d = ~(target_boot & ~exec_boot);
        // RULE_05 mask interrupts in boot
        irq_d = exec_boot & ~vectors_in_boot;
      end
      // RULE_04 app loads from boot blocked
      flcs_pkg::FLCS_BLOCK_M4: begin
        load_d = ~(target_boot & ~exec_boot);
        // RULE_05 mask interrupts in boot
        irq_d = exec_boot & ~vectors_in_boot;
      end
      default: begin
        store_d = 1'b0;
        load_d = 1'b0;
      end
    endcase
  end

  // register permission outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      store_permit_q <= 1'b0;
      load_permit_q <= 1'b0;
      irq_block_q <= 1'b0;
    end else begin
      store_permit_q <= store_d;
      load_permit_q <= load_d;
      irq_block_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // signature row and oscillator trim

  logic [7:0] sig_d; // read data next value
  logic [7:0] cal_byte; // selected calibration byte
  logic [7:0] trim_d; // trim register next value

  // look up identity and calibration bytes
  always_comb begin
    sig_d = sig_rd_data_q;
    // RULE_20 calibration in the high byte
    case (sig_rd_addr)
      2'h0: cal_byte = CAL_1MHZ;
      2'h1: cal_byte = CAL_2MHZ;
      2'h2: cal_byte = CAL_4MHZ;
      default: cal_byte = CAL_8MHZ;
    endcase
    // RULE_19 identity readable regardless of locks
    if (sig_rd_en) begin
      if (sig_rd_high) begin
        sig_d = cal_byte;
      end else if (sig_rd_addr == flcs_pkg::SIG_ADDR_FIRST) begin
        sig_d = ID_BYTE0;
      end else if (sig_rd_addr < flcs_pkg::SIG_ADDR_LAST) begin
        sig_d = ID_BYTE1;
      end else if (sig_rd_addr == flcs_pkg::SIG_ADDR_LAST) begin
        sig_d = ID_BYTE2;
      end else begin
        sig_d = flcs_pkg::UNMAPPED_READ;
      end
    end
    trim_d = osc_trim_register_q;
    if (osc_trim_wr) begin
      trim_d = osc_trim_wdata;
    end
  end

  // register signature read and trim value
  always_ff @(posedge clk) begin
    if (rst) begin
      sig_rd_data_q <= flcs_pkg::UNMAPPED_READ;
      // RULE_21 load 1 MHz calibration
      osc_trim_register_q <= CAL_1MHZ;
    end else begin
      sig_rd_data_q <= sig_d;
      osc_trim_register_q <= trim_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page geometry

  // split flash and eeprom addresses into page and offset
  always_ff @(posedge clk) begin
    if (rst) begin
      page_number_q <= 7'h00;
      page_word_index_q <= 6'h00;
      ee_page_number_q <= 7'h00;
      ee_byte_index_q <= 2'h0;
    end else begin
      // RULE_22 flash page and word split
      page_number_q <= target_addr[12:6];
      page_word_index_q <= target_addr[5:0];
      // RULE_23 eeprom page and byte split
      ee_page_number_q <= eeprom_addr[8:2];
      ee_byte_index_q <= eeprom_addr[1:0];
    end
  end

endmodule

// file: hdl/flcs_pkg.sv
// constants shared by the fuse, lock and configuration store
package flcs_pkg;
  // fuse high byte field positions
  localparam int unsigned HI_DEBUG_EN_BIT = 7;
  localparam int unsigned HI_BOUNDARY_EN_BIT = 6;
  localparam int unsigned HI_SERIAL_PROG_BIT = 5;
  localparam int unsigned HI_OSC_OPTION_BIT = 4;
  localparam int unsigned HI_EE_PRESERVE_BIT = 3;
  localparam int unsigned HI_BOOT_SIZE_HI_BIT = 2;
  localparam int unsigned HI_BOOT_SIZE_LO_BIT = 1;
  localparam int unsigned HI_RESET_VEC_BIT = 0;
  // fuse low byte field positions
  localparam int unsigned LO_BROWNOUT_LVL_BIT = 7;
  localparam int unsigned LO_BROWNOUT_EN_BIT = 6;
  localparam int unsigned LO_STARTUP_HI_BIT = 5;
  localparam int unsigned LO_STARTUP_LO_BIT = 4;
  localparam int unsigned LO_CLK_SEL_MSB = 3;
  // lock byte field positions
  localparam int unsigned LOCK_BOOT_UPPER_BIT = 5;
  localparam int unsigned LOCK_BOOT_LOWER_BIT = 4;
  localparam int unsigned LOCK_GENERAL_FIRST_BIT = 0;
  // reset (erased) values: 0 = programmed, 1 = unprogrammed
  localparam logic [7:0] FUSE_HIGH_RESET = 8'h99;
  localparam logic [7:0] FUSE_LOW_RESET = 8'he1;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // signature row addresses
  localparam logic [1:0] SIG_ADDR_FIRST = 2'h0;
  localparam logic [1:0] SIG_ADDR_LAST = 2'h2;
  localparam logic [1:0] CAL_ADDR_1MHZ = 2'h0;
  // boot section start word addresses by boot size code
  localparam logic [12:0] BOOT_START_SZ11 = 13'h1f80;
  localparam logic [12:0] BOOT_START_SZ10 = 13'h1f00;
  localparam logic [12:0] BOOT_START_SZ01 = 13'h1e00;
  localparam logic [12:0] BOOT_START_SZ00 = 13'h1c00;
  // page geometry
  localparam int unsigned FLASH_PC_WIDTH = 13;
  localparam int unsigned FLASH_WORD_BITS = 6;
  localparam int unsigned FLASH_PAGE_BITS = 7;
  localparam int unsigned EE_ADDR_WIDTH = 9;
  localparam int unsigned EE_BYTE_BITS = 2;
  localparam int unsigned EE_PAGE_BITS = 7;
  // boot lock modes encoded as {upper, lower}
  typedef enum logic [1:0] {
    FLCS_BLOCK_M3 = 2'b00,
    FLCS_BLOCK_M4 = 2'b01,
    FLCS_BLOCK_M2 = 2'b10,
    FLCS_BLOCK_M1 = 2'b11
  } flcs_boot_lock_t;
endpackage

// file: sim/flcs_fuse_lock_config_store_chk.sv
// assertions on the fuse, lock and configuration store ports
`timescale 1ns/1ps
module flcs_chk #(
  parameter logic [7:0] CAL_1MHZ = 8'h80
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] lock_bits,
  input wire logic [12:0] exec_pc,
  input wire logic [12:0] target_addr,
  input wire logic vectors_in_boot,
  input wire logic [7:0] fuse_high_active_q,
  input wire logic store_permit_q,
  input wire logic load_permit_q,
  input wire logic irq_block_q,
  input wire logic sig_rd_en,
  input wire logic sig_rd_high,
  input wire logic [1:0] sig_rd_addr,
  input wire logic [7:0] sig_rd_data_q,
  input wire logic osc_trim_wr,
  input wire logic [7:0] osc_trim_wdata,
  input wire logic [7:0] osc_trim_register_q,
  input wire logic eeprom_preserve_q,
  input wire logic [8:0] eeprom_addr,
  input wire logic [6:0] page_number_q,
  input wire logic [5:0] page_word_index_q,
  input wire logic [6:0] ee_page_number_q,
  input wire logic [1:0] ee_byte_index_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // word address inside the boot section for a size code
  function automatic logic in_boot(input logic [12:0] a,
                                   input logic [1:0] sz);
    case (sz)
      2'b11: return a >= flcs_pkg::BOOT_START_SZ11;
      2'b10: return a >= flcs_pkg::BOOT_START_SZ10;
      2'b01: return a >= flcs_pkg::BOOT_START_SZ01;
      default: return a >= flcs_pkg::BOOT_START_SZ00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  store_gate_a: assert property (!$past(rst) |->
    store_permit_q == !(!$past(lock_bits[4]) && in_boot($past(target_addr),
    $past(fuse_high_active_q[2:1])))) else $error("store permit wrong");
  load_gate_a: assert property (!$past(rst) |->
    load_permit_q == !(!$past(lock_bits[5]) && in_boot($past(target_addr),
    $past(fuse_high_active_q[2:1])) && !in_boot($past(exec_pc),
    $past(fuse_high_active_q[2:1])))) else $error("load permit wrong");
  irq_hold_a: assert property (!$past(rst) |->
    irq_block_q == (!$past(lock_bits[5]) && !$past(vectors_in_boot) &&
    in_boot($past(exec_pc), $past(fuse_high_active_q[2:1]))))
    else $error("irq block wrong");
  cal_read_a: assert property (sig_rd_en && sig_rd_high &&
    sig_rd_addr == 2'h0 |=> sig_rd_data_q == CAL_1MHZ)
    else $error("calibration byte wrong");
  trim_reset_a: assert property ($fell(rst) |->
    osc_trim_register_q == CAL_1MHZ) else $error("trim reset wrong");
  trim_write_a: assert property (osc_trim_wr |=>
    osc_trim_register_q == $past(osc_trim_wdata)) else $error("trim wrong");
  preserve_on_a: assert property (!fuse_high_active_q[3] |=>
    eeprom_preserve_q) else $error("preserve not applied");
  flash_page_a: assert property (!$past(rst) |->
    {page_number_q, page_word_index_q} == $past(target_addr))
    else $error("flash page split wrong");
  ee_page_a: assert property (!$past(rst) |->
    {ee_page_number_q, ee_byte_index_q} == $past(eeprom_addr))
    else $error("eeprom page split wrong");
endmodule
bind flcs_fuse_lock_config_store flcs_chk #(.CAL_1MHZ(CAL_1MHZ)) u_chk (
  .clk(clk), .rst(rst), .lock_bits(lock_bits), .exec_pc(exec_pc),
  .target_addr(target_addr), .vectors_in_boot(vectors_in_boot),
  .fuse_high_active_q(fuse_high_active_q), .store_permit_q(store_permit_q),
  .load_permit_q(load_permit_q), .irq_block_q(irq_block_q),
  .sig_rd_en(sig_rd_en), .sig_rd_high(sig_rd_high),
  .sig_rd_addr(sig_rd_addr), .sig_rd_data_q(sig_rd_data_q),
  .osc_trim_wr(osc_trim_wr), .osc_trim_wdata(osc_trim_wdata),
  .osc_trim_register_q(osc_trim_register_q),
  .eeprom_preserve_q(eeprom_preserve_q), .eeprom_addr(eeprom_addr),
  .page_number_q(page_number_q), .page_word_index_q(page_word_index_q),
  .ee_page_number_q(ee_page_number_q), .ee_byte_index_q(ee_byte_index_q));

// file: sim/flcs_prog_model.sv
// programmer-side model holding the lock byte for the store
`timescale 1ns/1ps
module flcs_prog_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic lock_wr,
  input wire logic [7:0] lock_wdata,
  input wire logic fuses_done,
  output logic [7:0] lock_bits
);
  ////////////////////////////////////////////////////////////////////////
  // lock byte, erased value all ones
  logic [7:0] lock_q;
  assign lock_bits = lock_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= 8'hff;
    end else if (lock_wr && fuses_done) begin
      lock_q <= lock_wdata;
    end
  end
endmodule

// file: sim/testbench.sv
// self-checking bench for the fuse, lock and configuration store
`timescale 1ns/1ps
module testbench;
  // arbitrary identity values, last entry is the empty fourth row
  localparam logic [7:0] IDS [4] = '{8'h6d, 8'h2b, 8'h47, 8'hff};
  localparam logic [7:0] CALS [4] = '{8'h90, 8'h91, 8'h92, 8'h93};
  logic clk = 1'b0, rst = 1'b1, prog_mode_pin = 1'b0, serial_mode_pin = 1'b0;
  logic fuse_wr_en = 1'b0, fuse_wr_high = 1'b0, fuse_rd_en = 1'b0;
  logic fuse_rd_high = 1'b0, sig_rd_en = 1'b0, sig_rd_high = 1'b0;
  logic vectors_in_boot = 1'b0, osc_trim_wr = 1'b0, lock_wr = 1'b0;
  logic fuses_done = 1'b0, store_permit_q, load_permit_q, irq_block_q;
  logic eeprom_preserve_q;
  logic [1:0] sig_rd_addr = 2'h0, ee_byte_index_q;
  logic [7:0] fuse_wr_data = 8'h00, osc_trim_wdata = 8'h00;
  logic [7:0] lock_wdata = 8'hff, lock_bits, fuse_rd_data_q, sig_rd_data_q;
  logic [7:0] osc_trim_register_q, fuse_high_active_q, fuse_low_active_q;
  logic [12:0] exec_pc = 13'h0000, target_addr = 13'h0000;
  logic [8:0] eeprom_addr = 9'h000;
  logic [6:0] page_number_q, ee_page_number_q;
  logic [5:0] page_word_index_q;
  int num_errors = 0, num_checks = 0, cycles = 0, m, k;
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  flcs_prog_model u_prog (.clk(clk), .rst(rst), .lock_wr(lock_wr),
    .lock_wdata(lock_wdata), .fuses_done(fuses_done), .lock_bits(lock_bits));
  flcs_fuse_lock_config_store #(.ID_BYTE0(IDS[0]), .ID_BYTE1(IDS[1]),
    .ID_BYTE2(IDS[2]), .CAL_1MHZ(CALS[0]), .CAL_2MHZ(CALS[1]),
    .CAL_4MHZ(CALS[2]), .CAL_8MHZ(CALS[3])) u_dut (.clk(clk), .rst(rst),
    .prog_mode_pin(prog_mode_pin), .serial_mode_pin(serial_mode_pin),
    .fuse_wr_en(fuse_wr_en), .fuse_wr_high(fuse_wr_high),
    .fuse_wr_data(fuse_wr_data), .fuse_rd_en(fuse_rd_en),
    .fuse_rd_high(fuse_rd_high), .fuse_rd_data_q(fuse_rd_data_q),
    .sig_rd_en(sig_rd_en), .sig_rd_high(sig_rd_high),
    .sig_rd_addr(sig_rd_addr), .sig_rd_data_q(sig_rd_data_q),
    .lock_bits(lock_bits), .exec_pc(exec_pc), .target_addr(target_addr),
    .vectors_in_boot(vectors_in_boot), .osc_trim_wr(osc_trim_wr),
    .osc_trim_wdata(osc_trim_wdata), .osc_trim_register_q(osc_trim_register_q),
    .store_permit_q(store_permit_q), .load_permit_q(load_permit_q),
    .irq_block_q(irq_block_q), .fuse_high_active_q(fuse_high_active_q),
    .fuse_low_active_q(fuse_low_active_q),
    .eeprom_preserve_q(eeprom_preserve_q), .eeprom_addr(eeprom_addr),
    .page_number_q(page_number_q), .page_word_index_q(page_word_index_q),
    .ee_page_number_q(ee_page_number_q), .ee_byte_index_q(ee_byte_index_q));
  ////////////////////////////////////////////////////////////////////////
  // access tasks, all entered and left at a falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic fwr(input logic hi, input logic [7:0] d);
    fuse_wr_en = 1'b1;
    fuse_wr_high = hi;
    fuse_wr_data = d;
    tick(1);
    fuse_wr_en = 1'b0;
    tick(1);
  endtask
  task automatic fread(input logic hi);
    fuse_rd_en = 1'b1;
    fuse_rd_high = hi;
    tick(1);
    fuse_rd_en = 1'b0;
    tick(1);
  endtask
  task automatic sread(input logic hi, input logic [1:0] a);
    sig_rd_en = 1'b1;
    sig_rd_high = hi;
    sig_rd_addr = a;
    tick(1);
    sig_rd_en = 1'b0;
    tick(1);
  endtask
  task automatic set_lock(input logic [7:0] v);
    lock_wr = 1'b1;
    lock_wdata = v;
    tick(1);
    lock_wr = 1'b0;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(5);
    rst = 1'b0;
    tick(2);
    fread(1'b1);
    chk("fuse high", 8'h99, fuse_rd_data_q);
    fread(1'b0);
    chk("fuse low", 8'he1, fuse_rd_data_q);
    chk("active high", 8'h99, fuse_high_active_q);
    chk("trim", CALS[0], osc_trim_register_q);
    chk1("preserve off", 1'b0, eeprom_preserve_q);
    // programming session, preserve and boot size 01 programmed
    prog_mode_pin = 1'b1;
    tick(8);
    fwr(1'b1, 8'h93);
    fwr(1'b0, 8'h2f);
    fread(1'b1);
    chk("stored high", 8'h93, fuse_rd_data_q);
    chk("active frozen", 8'h99, fuse_high_active_q);
    chk1("preserve on", 1'b1, eeprom_preserve_q);
    serial_mode_pin = 1'b1;
    tick(6);
    // boot size moves to 10, serial enable bit must keep its old zero
    fwr(1'b1, 8'hb5);
    fread(1'b1);
    chk("serial enable kept", 8'h95, fuse_rd_data_q);
    serial_mode_pin = 1'b0;
    prog_mode_pin = 1'b0;
    tick(8);
    chk("active high", 8'h95, fuse_high_active_q);
    chk("active low", 8'h2f, fuse_low_active_q);
    fuses_done = 1'b1;
    // every boot lock mode against boundary addresses of a 1f00 boot
    for (m = 0; m < 4; m++) begin
      set_lock({2'b11, m[1:0], 4'hf});
      for (k = 0; k < 8; k++) begin
        target_addr = k[0] ? 13'h1f00 : 13'h1eff;
        exec_pc = k[1] ? 13'h1fff : 13'h0000;
        vectors_in_boot = k[2];
        eeprom_addr = {k[2:0], 6'h27};
        tick(1);
        chk1("store", m[0] | ~k[0], store_permit_q);
        chk1("load", m[1] | ~k[0] | k[1], load_permit_q);
        chk1("irq", ~m[1] & k[1] & ~k[2], irq_block_q);
        // page split of the boundary and eeprom addresses
        chk1("page", 1'b1, page_number_q == 7'h7b + k[0]);
        chk1("word", 1'b1, page_word_index_q == {6{~k[0]}});
        chk1("ee page", 1'b1, ee_page_number_q == {k[2:0], 4'h9});
        chk1("ee byte", 1'b1, ee_byte_index_q == 2'h3);
      end
    end
    // general lock programmed, fuse writes refused, signature readable
    set_lock(8'hfe);
    prog_mode_pin = 1'b1;
    tick(8);
    fwr(1'b0, 8'hff);
    fread(1'b0);
    chk("locked low", 8'h2f, fuse_rd_data_q);
    for (k = 0; k < 4; k++) begin
      sread(1'b0, k[1:0]);
      chk("identity", IDS[k], sig_rd_data_q);
      sread(1'b1, k[1:0]);
      chk("calibration", CALS[k], sig_rd_data_q);
    end
    osc_trim_wr = 1'b1;
    osc_trim_wdata = 8'h5c;
    tick(1);
    osc_trim_wr = 1'b0;
    tick(1);
    chk("trim write", 8'h5c, osc_trim_register_q);
    finish_test();
  end
endmodule
